// ---- dv/mdoc_asserts.sv ----
// port-level checks of the digital output block
`default_nettype none
`include "mdoc_regs.svh"

module mdoc_asserts #(
  parameter int NUM_ALARMS = 8,
  parameter int TICK_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire mdoc_pkg::mdoc_bus_req_t bus_req,
  input wire logic [`MDOC_DATA_W-1:0] bus_rdata,
  input wire logic [2:0] dmd_end,
  input wire logic energy_pulse,
  input wire logic [`MDOC_RATE_W-1:0] energy_rate,
  input wire mdoc_pkg::mdoc_cfg_t nv_cfg_out,
  input wire logic nv_coil_out,
  input wire logic nv_wr,
  input wire logic dout
);
  import mdoc_pkg::*;
  logic cmd_on, cmd_rel, ont_wr, en_wr, sel_end;
  logic [13:0] ont_q;
  logic [31:0] hi_q;
  // counts edges after reset rises so checks wait out the two-flop release and the restore cycle
  logic [2:0] live_q;
  assign cmd_on = bus_req.we && bus_req.addr == `MDOC_OFS_CMD && bus_req.wdata[0];
  assign cmd_rel = bus_req.we && bus_req.addr == `MDOC_OFS_CMD && bus_req.wdata[2];
  assign ont_wr = bus_req.we && bus_req.addr == `MDOC_OFS_ON_TIME && bus_req.wdata <= 32'h270F;
  assign en_wr = bus_req.we && bus_req.addr == `MDOC_OFS_ENERGY;
  assign sel_end = dmd_end[nv_cfg_out.dmd_sel];
  // shadow of the duration so pulse length is judged from the ports alone
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ont_q <= '0;
      hi_q <= '0;
      live_q <= '0;
    end else begin
      if (live_q != 3'h6) begin
        live_q <= live_q + 3'h1;
      end
      if (ont_wr) begin
        ont_q <= bus_req.wdata[13:0];
      end
      hi_q <= dout ? hi_q + 32'h1 : 32'h0;
    end
  end
  // -----
  // properties
  // -----
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n || live_q != 3'h6);
  rdata_idle_a: assert property (!$past(bus_req.re) |-> bus_rdata == '0)
    else $error("read data without a read");
  cfg_write_a: assert property (bus_req.we && bus_req.addr == `MDOC_OFS_CTRL
    |=> nv_cfg_out == $past(bus_req.wdata[5:0])) else $error("control write lost");
  rate_write_a: assert property (en_wr && bus_req.wdata[23:0] != 24'h0
    && bus_req.wdata[23:0] <= `MDOC_RATE_MAX |=> energy_rate == $past(bus_req.wdata[23:0]))
    else $error("rate write lost");
  rate_keep_a: assert property (en_wr && bus_req.wdata[23:0] == 24'h0 |=> $stable(energy_rate))
    else $error("zero rate accepted");
  energy_follow_a: assert property ($past(nv_cfg_out.ctrl) == MDOC_CM_ENERGY
    |-> dout == $past(energy_pulse)) else $error("output not following energy pulse");
  ext_rise_a: assert property ($rose(dout) && $past(nv_cfg_out.ctrl) == MDOC_CM_EXTERNAL
    && $past(nv_cfg_out.beh) != MDOC_BM_COIL |-> $past(cmd_on)) else $error("rise without on command");
  dmd_rise_a: assert property ($rose(dout) && $past(nv_cfg_out.ctrl) == MDOC_CM_DEMAND
    |-> $past(ont_q) != 14'h0 && $past(sel_end) && !$past(sel_end, 2)) else $error("stray demand pulse");
  dmd_len_a: assert property ($fell(dout) && $past(nv_cfg_out.ctrl) == MDOC_CM_DEMAND
    |-> hi_q >= ont_q * TICK_CYCLES) else $error("demand pulse too short");
  coil_fall_a: assert property ($fell(dout) && $past(nv_cfg_out.ctrl) == MDOC_CM_EXTERNAL
    && $past(nv_cfg_out.beh) == MDOC_BM_COIL |-> $past(cmd_rel)) else $error("coil dropped without release");
  nv_wr_a: assert property ($changed(nv_cfg_out) || $changed(nv_coil_out) |-> nv_wr)
    else $error("state change not stored");
endmodule

bind mdoc_top mdoc_asserts #(.NUM_ALARMS(NUM_ALARMS), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .dmd_end(dmd_end),
  .energy_pulse(energy_pulse), .energy_rate(energy_rate), .nv_cfg_out(nv_cfg_out),
  .nv_coil_out(nv_coil_out), .nv_wr(nv_wr), .dout(dout));
`default_nettype wire

// ---- dv/mdoc_nv_store.sv ----
// nonvolatile store that keeps the setup and coil state beside the block
`default_nettype none

module mdoc_nv_store (
  input wire logic mclk,
  input wire logic nv_wr,
  input wire mdoc_pkg::mdoc_cfg_t nv_cfg_out,
  input wire logic nv_coil_out,
  output mdoc_pkg::mdoc_cfg_t nv_cfg_in,
  output logic nv_coil_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import mdoc_pkg::*;
  // no reset on purpose: contents must outlive a loss of control power
  initial begin
    nv_cfg_in = '0;
    nv_coil_in = 1'b0;
  end
  always @(posedge mclk) begin
    if (nv_wr) begin
      nv_cfg_in <= nv_cfg_out;
      nv_coil_in <= nv_coil_out;
    end
  end
endmodule
`default_nettype wire

// ---- dv/meter_digital_output_control_tb.sv ----
// self-checking bench of the digital output control block
`default_nettype none
`include "mdoc_regs.svh"

module meter_digital_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mdoc_pkg::*;
  typedef struct {
    logic [5:0] cfg;
    logic [13:0] ont;
    logic [1:0] ev;
    logic [7:0] val;
    logic [31:0] exp;
  } mdoc_row_t;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  mdoc_bus_req_t bus_req = '0;
  logic [2:0] dmd_end = '0;
  logic [7:0] alarm_trig = '0;
  logic energy_pulse = 1'b0;
  logic [31:0] bus_rdata;
  logic [3:0] energy_ch;
  logic [23:0] energy_rate;
  mdoc_cfg_t nv_cfg_in;
  mdoc_cfg_t nv_cfg_out;
  logic nv_coil_in, nv_coil_out, nv_wr, dout;
  logic [31:0] got;
  int bad_count = 0;
  int compares = 0;
  // pulse cycles counted over a 48-cycle window; 48 means held
  mdoc_row_t rows[13] = '{
    '{6'h00, 14'h0, 2'h0, 8'h01, 32'h30}, '{6'h04, 14'h2, 2'h0, 8'h01, 32'h8},
    '{6'h04, 14'h0, 2'h0, 8'h01, 32'h0}, '{6'h11, 14'h3, 2'h1, 8'h02, 32'hC},
    '{6'h11, 14'h3, 2'h1, 8'h01, 32'h0}, '{6'h21, 14'h1, 2'h1, 8'h04, 32'h4},
    '{6'h02, 14'h0, 2'h2, 8'h04, 32'h30}, '{6'h02, 14'h0, 2'h2, 8'h02, 32'h0},
    '{6'h06, 14'h2, 2'h2, 8'h01, 32'h8}, '{6'h03, 14'h0, 2'h3, 8'h00, 32'h2},
    '{6'h02, 14'h0, 2'h0, 8'h01, 32'h0}, '{6'h01, 14'h1, 2'h0, 8'h01, 32'h0},
    '{6'h08, 14'h0, 2'h0, 8'h01, 32'h30}};

  always #2 mclk = ~mclk;

  mdoc_top #(.NUM_ALARMS(8), .TICK_CYCLES(4)) dut (
    .mclk(mclk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .dmd_end(dmd_end),
    .alarm_trig(alarm_trig), .energy_pulse(energy_pulse), .energy_ch(energy_ch), .energy_rate(energy_rate),
    .nv_cfg_in(nv_cfg_in), .nv_coil_in(nv_coil_in), .nv_cfg_out(nv_cfg_out), .nv_coil_out(nv_coil_out),
    .nv_wr(nv_wr), .dout(dout));

  mdoc_nv_store u_nv (.mclk(mclk), .nv_wr(nv_wr), .nv_cfg_out(nv_cfg_out), .nv_coil_out(nv_coil_out),
    .nv_cfg_in(nv_cfg_in), .nv_coil_in(nv_coil_in));

  // -----
  // tasks
  // -----
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // strobe dropped and one edge let pass, so back-to-back calls never reassign it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.we <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge mclk);
    bus_req.we <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_req.re <= 1'b1;
    bus_req.addr <= a;
    @(posedge mclk);
    bus_req.re <= 1'b0;
    #1 d = bus_rdata;
    @(posedge mclk);
  endtask

  task automatic win(input int n, output logic [31:0] c);
    c = '0;
    repeat (n) begin
      #1 c = c + dout;
      @(posedge mclk);
    end
  endtask

  initial begin
    #100000;
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("dout_rst", {31'h0, dout}, 32'h0);
    chk("rate_rst", {8'h0, energy_rate}, 32'h1);
    $display("reset test done");
    wr(`MDOC_OFS_ALARM_MASK, 32'h5);
    foreach (rows[i]) begin
      wr(`MDOC_OFS_CTRL, {26'h0, rows[i].cfg});
      wr(`MDOC_OFS_ON_TIME, {18'h0, rows[i].ont});
      // the window opens right after the edge that takes the trigger, so no output cycle is missed
      if (rows[i].ev == 2'h0) begin
        bus_req.we <= 1'b1;
        bus_req.addr <= `MDOC_OFS_CMD;
        bus_req.wdata <= {24'h0, rows[i].val};
        @(posedge mclk);
        bus_req.we <= 1'b0;
      end else begin
        dmd_end <= rows[i].ev == 2'h1 ? rows[i].val[2:0] : 3'h0;
        alarm_trig <= rows[i].ev == 2'h2 ? rows[i].val : 8'h00;
        energy_pulse <= rows[i].ev == 2'h3;
        @(posedge mclk);
        fork
          begin
            @(posedge mclk);
            energy_pulse <= 1'b0;
          end
        join_none
      end
      win(48, got);
      chk("pulse_cycles", got, rows[i].exp);
      dmd_end <= '0;
      alarm_trig <= '0;
      wr(`MDOC_OFS_CMD, 32'h6);
      wr(`MDOC_OFS_CTRL, 32'h0);
      $display("row %0d done", i);
    end
    wr(`MDOC_OFS_ON_TIME, 32'h270F);
    wr(`MDOC_OFS_ON_TIME, 32'h2710);
    rd(`MDOC_OFS_ON_TIME, got);
    chk("on_time", got, 32'h270F);
    rd(8'h18, got);
    chk("unmapped", got, 32'h0);
    wr(`MDOC_OFS_ENERGY, 32'h0898967F);
    wr(`MDOC_OFS_ENERGY, 32'h09000000);
    chk("rate", {8'h0, energy_rate}, 32'h98967F);
    chk("channel", {28'h0, energy_ch}, 32'h8);
    $display("register test done");
    wr(`MDOC_OFS_CTRL, 32'h1);
    wr(`MDOC_OFS_ON_TIME, 32'h1);
    dmd_end <= 3'h1;
    @(posedge mclk);
    dmd_end <= 3'h0;
    fork
      begin
        @(posedge mclk);
        dmd_end <= 3'h1;
      end
    join_none
    win(20, got);
    chk("retrigger", got, 32'h6);
    dmd_end <= 3'h0;
    $display("retrigger test done");
    wr(`MDOC_OFS_CTRL, 32'h8);
    wr(`MDOC_OFS_CMD, 32'h1);
    wr(`MDOC_OFS_CMD, 32'h2);
    #1 chk("coil_off", {31'h0, dout}, 32'h1);
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk("coil_restore", {31'h0, dout}, 32'h1);
    chk("cfg_restore", {26'h0, nv_cfg_out}, 32'h8);
    @(posedge mclk);
    wr(`MDOC_OFS_CMD, 32'h4);
    #1 chk("coil_release", {31'h0, dout}, 32'h0);
    $display("coil test done");
    end_sim();
  end
endmodule
`default_nettype wire

// ---- src/mdoc_pkg.sv ----
// types shared by the digital output control block
`default_nettype none
`include "mdoc_regs.svh"

package mdoc_pkg;

  typedef enum logic [1:0] {
    MDOC_CM_EXTERNAL,
    MDOC_CM_DEMAND,
    MDOC_CM_ALARM,
    MDOC_CM_ENERGY
  } mdoc_ctrl_mode_t;

  typedef enum logic [1:0] {
    MDOC_BM_NORMAL,
    MDOC_BM_TIMED,
    MDOC_BM_COIL,
    MDOC_BM_RSVD
  } mdoc_beh_mode_t;

  typedef enum logic [1:0] {
    MDOC_DS_POWER,
    MDOC_DS_CURRENT,
    MDOC_DS_INPUT,
    MDOC_DS_RSVD
  } mdoc_dmd_sel_t;

  typedef struct packed {
    mdoc_dmd_sel_t dmd_sel;
    mdoc_beh_mode_t beh;
    mdoc_ctrl_mode_t ctrl;
  } mdoc_cfg_t;

  typedef struct packed {
    logic [`MDOC_ADDR_W-1:0] addr;
    logic [`MDOC_DATA_W-1:0] wdata;
    logic we;
    logic re;
  } mdoc_bus_req_t;

endpackage

`default_nettype wire

// ---- src/mdoc_regs.svh ----
// register offsets, field positions, reset values and timing counts of the digital output block
`ifndef MDOC_REGS_SVH
`define MDOC_REGS_SVH

// ---------------------------------------------------------------
// bus shape
// ---------------------------------------------------------------
`define MDOC_ADDR_W 8
`define MDOC_DATA_W 32

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define MDOC_OFS_CTRL 8'h00
`define MDOC_OFS_ON_TIME 8'h04
`define MDOC_OFS_ALARM_MASK 8'h08
`define MDOC_OFS_CMD 8'h0C
`define MDOC_OFS_STATUS 8'h10
`define MDOC_OFS_ENERGY 8'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MDOC_CTRL_MODE_LSB 0
`define MDOC_CTRL_BEH_LSB 2
`define MDOC_CTRL_DSEL_LSB 4
`define MDOC_CMD_ON_BIT 0
`define MDOC_CMD_OFF_BIT 1
`define MDOC_CMD_REL_BIT 2
`define MDOC_STAT_OUT_BIT 0
`define MDOC_STAT_HOLD_BIT 1
`define MDOC_STAT_COIL_BIT 2
`define MDOC_STAT_REM_LSB 16
`define MDOC_ENERGY_RATE_LSB 0
`define MDOC_ENERGY_CH_LSB 24

// ---------------------------------------------------------------
// widths, ranges and reset values
// ---------------------------------------------------------------
`define MDOC_ON_TIME_W 14
`define MDOC_ON_TIME_MAX 14'h270F
`define MDOC_ON_TIME_RST 14'h0000
`define MDOC_RATE_W 24
`define MDOC_RATE_MIN 24'h000001
`define MDOC_RATE_MAX 24'h98967F
`define MDOC_RATE_RST 24'h000001
`define MDOC_ECH_W 4
`define MDOC_ECH_MAX 4'h8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MDOC_CLK_HZ 250000000
`define MDOC_TICK_S 1

`endif

// ---- src/mdoc_top.sv ----
// digital output control: source and hold behaviour of one discrete meter output
`default_nettype none
`include "mdoc_regs.svh"

module mdoc_top #(
  parameter int NUM_ALARMS = 8,
  parameter int TICK_CYCLES = `MDOC_CLK_HZ * `MDOC_TICK_S
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire mdoc_pkg::mdoc_bus_req_t bus_req,
  output logic [`MDOC_DATA_W-1:0] bus_rdata,
  input wire logic [2:0] dmd_end,
  input wire logic [NUM_ALARMS-1:0] alarm_trig,
  input wire logic energy_pulse,
  output logic [`MDOC_ECH_W-1:0] energy_ch,
  output logic [`MDOC_RATE_W-1:0] energy_rate,
  input wire mdoc_pkg::mdoc_cfg_t nv_cfg_in,
  input wire logic nv_coil_in,
  output mdoc_pkg::mdoc_cfg_t nv_cfg_out,
  output logic nv_coil_out,
  output logic nv_wr,
  output logic dout
);
  import mdoc_pkg::*;

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic restored_q, restored_d;
  mdoc_cfg_t cfg_q, cfg_d;
  logic [`MDOC_ON_TIME_W-1:0] on_time_q, on_time_d;
  logic [NUM_ALARMS-1:0] alarm_mask_q, alarm_mask_d;
  logic [`MDOC_RATE_W-1:0] rate_q, rate_d;
  logic [`MDOC_ECH_W-1:0] ech_q, ech_d;
  logic hold_q, hold_d;
  logic coil_q, coil_d;
  logic [`MDOC_ON_TIME_W-1:0] remain_q, remain_d;
  logic [TW-1:0] tick_q, tick_d;
  logic [2:0] dmd_prev_q;
  logic [NUM_ALARMS-1:0] alarm_prev_q;
  logic dout_q, dout_d;
  logic nv_wr_q, nv_wr_d;
  logic [`MDOC_DATA_W-1:0] rdata_q, rdata_d;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  logic wr_ctrl, wr_on_time, wr_mask, wr_cmd, wr_energy;
  logic cmd_on, cmd_off, cmd_rel;
  logic [`MDOC_ON_TIME_W-1:0] wr_on_val;
  logic [`MDOC_RATE_W-1:0] wr_rate_val;
  logic [`MDOC_ECH_W-1:0] wr_ech_val;
  logic bus_open;

  // nothing is taken until the stored state has been brought back
  assign bus_open = restored_q;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_on_time = 1'b0;
    wr_mask = 1'b0;
    wr_cmd = 1'b0;
    wr_energy = 1'b0;
    if (bus_open && bus_req.we) begin
      if (bus_req.addr == `MDOC_OFS_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (bus_req.addr == `MDOC_OFS_ON_TIME) begin
        wr_on_time = 1'b1;
      end else if (bus_req.addr == `MDOC_OFS_ALARM_MASK) begin
        wr_mask = 1'b1;
      end else if (bus_req.addr == `MDOC_OFS_CMD) begin
        wr_cmd = 1'b1;
      end else if (bus_req.addr == `MDOC_OFS_ENERGY) begin
        wr_energy = 1'b1;
      end
    end
  end

  assign wr_on_val = bus_req.wdata[`MDOC_ON_TIME_W-1:0];
  assign wr_rate_val = bus_req.wdata[`MDOC_ENERGY_RATE_LSB +: `MDOC_RATE_W];
  assign wr_ech_val = bus_req.wdata[`MDOC_ENERGY_CH_LSB +: `MDOC_ECH_W];
  assign cmd_on = wr_cmd && bus_req.wdata[`MDOC_CMD_ON_BIT];
  assign cmd_off = wr_cmd && bus_req.wdata[`MDOC_CMD_OFF_BIT];
  assign cmd_rel = wr_cmd && bus_req.wdata[`MDOC_CMD_REL_BIT];

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  logic dmd_hit, alarm_hit;
  logic [2:0] dmd_rise;
  logic [NUM_ALARMS-1:0] alarm_rise;
  logic in_ext, in_dmd, in_alarm, in_energy;

  assign in_ext = (cfg_q.ctrl == MDOC_CM_EXTERNAL);
  assign in_dmd = (cfg_q.ctrl == MDOC_CM_DEMAND);
  assign in_alarm = (cfg_q.ctrl == MDOC_CM_ALARM);
  assign in_energy = (cfg_q.ctrl == MDOC_CM_ENERGY);

  assign dmd_rise = dmd_end & ~dmd_prev_q;
  assign alarm_rise = alarm_trig & ~alarm_prev_q;

  always_comb begin
    dmd_hit = 1'b0;
    case (cfg_q.dmd_sel)
      MDOC_DS_POWER: dmd_hit = dmd_rise[0];
      MDOC_DS_CURRENT: dmd_hit = dmd_rise[1];
      MDOC_DS_INPUT: dmd_hit = dmd_rise[2];
      default: dmd_hit = 1'b0;
    endcase
    dmd_hit = dmd_hit && in_dmd;
  end

  // any enabled alarm that goes active counts as one trigger
  assign alarm_hit = in_alarm && |(alarm_rise & alarm_mask_q);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic start_pulse;
  logic set_hold, clr_hold, set_coil, clr_coil;

  always_comb begin
    restored_d = 1'b1;
    cfg_d = cfg_q;
    on_time_d = on_time_q;
    alarm_mask_d = alarm_mask_q;
    rate_d = rate_q;
    ech_d = ech_q;
    hold_d = hold_q;
    coil_d = coil_q;
    remain_d = remain_q;
    tick_d = tick_q;
    start_pulse = 1'b0;
    set_hold = 1'b0;
    clr_hold = 1'b0;
    set_coil = 1'b0;
    clr_coil = 1'b0;

    if (!restored_q) begin
      // first cycle after release: bring back the stored setup and coil state
      cfg_d = nv_cfg_in;
      coil_d = nv_coil_in;
    end else begin
      if (wr_ctrl) begin
        cfg_d = mdoc_cfg_t'(bus_req.wdata[5:0]);
      end
      if (wr_on_time && bus_req.wdata[31:`MDOC_ON_TIME_W] == '0 && wr_on_val <= `MDOC_ON_TIME_MAX) begin
        on_time_d = wr_on_val;
      end
      if (wr_mask) begin
        alarm_mask_d = bus_req.wdata[NUM_ALARMS-1:0];
      end
      if (wr_energy) begin
        // an out-of-range rate or channel leaves that field as it was
        if (wr_rate_val >= `MDOC_RATE_MIN && wr_rate_val <= `MDOC_RATE_MAX) begin
          rate_d = wr_rate_val;
        end
        if (wr_ech_val <= `MDOC_ECH_MAX) begin
          ech_d = wr_ech_val;
        end
      end

      // sources per mode; on commands only reach the output in external mode, off and release act in external and alarm mode
      case (cfg_q.beh)
        MDOC_BM_NORMAL: begin
          set_hold = (in_ext && cmd_on) || alarm_hit;
          clr_hold = (in_ext || in_alarm) && cmd_off;
        end
        MDOC_BM_TIMED: begin
          start_pulse = (in_ext && cmd_on) || alarm_hit;
        end
        MDOC_BM_COIL: begin
          set_coil = (in_ext && cmd_on) || alarm_hit;
          clr_coil = (in_ext || in_alarm) && cmd_rel;
        end
        default: begin
          start_pulse = 1'b0;
        end
      endcase
      // demand sync always pulses for the programmed time
      if (dmd_hit) begin
        start_pulse = 1'b1;
      end

      // set wins over a clear in the same cycle
      if (set_hold) begin
        hold_d = 1'b1;
      end else if (clr_hold) begin
        hold_d = 1'b0;
      end
      if (set_coil) begin
        coil_d = 1'b1;
      end else if (clr_coil) begin
        coil_d = 1'b0;
      end
      if (!(in_ext || in_alarm)) begin
        hold_d = 1'b0;
      end

      // pulse timer: the tick restarts with each trigger so the width is exact
      if (start_pulse) begin
        remain_d = on_time_q;
        tick_d = '0;
      end else if (remain_q != '0) begin
        if (tick_q == TICK_LAST) begin
          tick_d = '0;
          remain_d = remain_q - 1'b1;
        end else begin
          tick_d = tick_q + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  always_comb begin
    dout_d = 1'b0;
    if (restored_q) begin
      case (cfg_q.ctrl)
        MDOC_CM_EXTERNAL, MDOC_CM_ALARM: begin
          case (cfg_q.beh)
            MDOC_BM_NORMAL: dout_d = hold_d;
            MDOC_BM_TIMED: dout_d = (remain_d != '0);
            MDOC_BM_COIL: dout_d = coil_d;
            default: dout_d = 1'b0;
          endcase
        end
        MDOC_CM_DEMAND: dout_d = (remain_d != '0);
        MDOC_CM_ENERGY: dout_d = energy_pulse;
        default: dout_d = 1'b0;
      endcase
    end
  end

  // nonvolatile copy is rewritten whenever setup or coil state moves, other than on the restore load
  assign nv_wr_d = restored_q && ((cfg_d != cfg_q) || (coil_d != coil_q));

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (bus_open && bus_req.re) begin
      if (bus_req.addr == `MDOC_OFS_CTRL) begin
        rdata_d[5:0] = cfg_q;
      end else if (bus_req.addr == `MDOC_OFS_ON_TIME) begin
        rdata_d[`MDOC_ON_TIME_W-1:0] = on_time_q;
      end else if (bus_req.addr == `MDOC_OFS_ALARM_MASK) begin
        rdata_d[NUM_ALARMS-1:0] = alarm_mask_q;
      end else if (bus_req.addr == `MDOC_OFS_STATUS) begin
        rdata_d[`MDOC_STAT_OUT_BIT] = dout_q;
        rdata_d[`MDOC_STAT_HOLD_BIT] = hold_q;
        rdata_d[`MDOC_STAT_COIL_BIT] = coil_q;
        rdata_d[`MDOC_STAT_REM_LSB +: `MDOC_ON_TIME_W] = remain_q;
      end else if (bus_req.addr == `MDOC_OFS_ENERGY) begin
        rdata_d[`MDOC_ENERGY_RATE_LSB +: `MDOC_RATE_W] = rate_q;
        rdata_d[`MDOC_ENERGY_CH_LSB +: `MDOC_ECH_W] = ech_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      restored_q <= 1'b0;
      cfg_q <= '0;
      on_time_q <= `MDOC_ON_TIME_RST;
      alarm_mask_q <= '0;
      rate_q <= `MDOC_RATE_RST;
      ech_q <= '0;
      hold_q <= 1'b0;
      coil_q <= 1'b0;
      remain_q <= '0;
      tick_q <= '0;
      dmd_prev_q <= '1;
      alarm_prev_q <= '1;
      dout_q <= 1'b0;
      nv_wr_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      restored_q <= restored_d;
      cfg_q <= cfg_d;
      on_time_q <= on_time_d;
      alarm_mask_q <= alarm_mask_d;
      rate_q <= rate_d;
      ech_q <= ech_d;
      hold_q <= hold_d;
      coil_q <= coil_d;
      remain_q <= remain_d;
      tick_q <= tick_d;
      dmd_prev_q <= dmd_end;
      alarm_prev_q <= alarm_trig;
      dout_q <= dout_d;
      nv_wr_q <= nv_wr_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign dout = dout_q;
  assign energy_ch = ech_q;
  assign energy_rate = rate_q;
  assign nv_cfg_out = cfg_q;
  assign nv_coil_out = coil_q;
  assign nv_wr = nv_wr_q;

endmodule

`default_nettype wire
